// ===== hdl/crs_core.v
// Processor register set, flag logic, opcode latch and bus release
//
// Overview of operation
// RL1: Storage is eighteen 8-bit registers and four 16-bit registers.
// RL2: An 8-bit accumulator holds operands and results.
// RL3: Eight-bit flag register; six bits change by instruction condition.
// RL4: Sign, zero, parity/overflow and carry are offered as branch conditions.
// RL5: Sign flag takes accumulator bit 7 after flag-affecting operations; CMP takes bit 7 of the compare result, block ops keep it.
// RL6: Zero flag is one when the result is all zeros.
// RL7: Block search sets zero flag when memory equals accumulator.
// RL8: Block I/O sets zero flag when byte counter reaches zero.
// RL9: Logical operations put even parity into the parity/overflow flag.
// RL10: Block search/transfer: P/V is one while pair counter nonzero.
// RL11: Copying refresh or page register to accumulator copies interrupt latch.
// RL12: Arithmetic sets overflow when signed result leaves +127..-128.
// RL13: Instruction class selects parity or overflow meaning.
// RL14: Carry flag records carry out of bit 7 or a borrow.
// RL15: Half carry and subtract flags exist but are not directly testable.
// RL16: External bus claim releases address and data buses.
// RL17: Fetched opcodes are latched, decoded and drive the datapath; here opcode_q is only latched and op_cmd drives the datapath.
// RL18: Half carry holds low-nibble carry/borrow and steers decimal adjust.
// RL19: Subtract marker records add or subtract for decimal adjust.
// RL20: Alternate bank reached only through the two exchange operations.
// RL21: Flag layout: sign 7, zero 6, half 4, p/v 2, subtract 1, carry 0.
`timescale 1ns/1ns
`default_nettype none
`include "crs_defines.vh"
module crs_core (
    input wire sys_clk,
    input wire rst,
    input wire opcode_strobe,
    input wire [7:0] data_in,
    input wire [3:0] op_cmd,
    input wire [7:0] operand,
    input wire [1:0] acc_src,
    input wire reg_wr,
    input wire [2:0] reg_sel,
    input wire [7:0] reg_wdata,
    input wire word_wr,
    input wire [1:0] word_sel,
    input wire [15:0] word_wdata,
    input wire ipage_wr,
    input wire refresh_inc,
    input wire interrupt_enable_latch,
    input wire external_bus_claim,
    input wire [15:0] addr_drive,
    input wire [7:0] data_drive,
    input wire data_dir_out,
    output reg [7:0] opcode_q,
    output reg [7:0] acc_q,
    output reg [7:0] flags_q,
    output reg [3:0] cond_q,
    output reg [15:0] addr_out_q,
    output reg addr_oe_n_q,
    output reg [7:0] data_out_q,
    output reg data_oe_n_q,
    output reg bus_released_q,
    output reg [47:0] gpr_q,
    output reg [63:0] word_regs_q,
    output reg [15:0] ipage_refr_q
);
    wire [7:0] alu_res;
    wire [7:0] alu_flags;
    wire [7:0] acc_main;
    wire [7:0] flg_main;
    wire [47:0] gpr_main;
    wire [6:0] bank_wr;
    wire [55:0] bank_wdata;
    wire swap_af;
    wire swap_gp;
    reg [7:0] acc_d;
    reg [7:0] flags_d;
    reg acc_wr;
    reg flg_wr;
    reg [7:0] ipage_q;
    reg [7:0] refr_q;
    reg [15:0] word_q [0:3];
    reg [7:0] b_next;
    reg [15:0] bc_next;
    reg gpr_upd;
    reg [15:0] pair_d;
    integer k;

    // Decoded exchange strobes from the op_cmd datapath command input
    assign swap_af = (op_cmd == `CRS_OP_EXAF); // [RL17] [RL20]
    assign swap_gp = (op_cmd == `CRS_OP_EXX); // [RL17] [RL20]

    crs_alu u_alu (
        .op(op_cmd),
        .a_in(acc_main),
        .b_in(operand),
        .f_in(flg_main),
        .res(alu_res),
        .f_out(alu_flags)
    );

    // Main and alternate banks: six general registers and one never-written pair swapped by EXAF
    genvar g;
    generate
        for (g = 0; g < 7; g = g + 1) begin : g_bank
            wire [7:0] m_q;
            wire [7:0] a_q;
            crs_bank #(.WIDTH(8)) u_reg (
                .sys_clk(sys_clk),
                .rst(rst),
                .wr_en(bank_wr[g]),
                .wr_data(bank_wdata[g*8 +: 8]),
                .swap(g == 6 ? swap_af : swap_gp),
                .main_q(m_q),
                .alt_q(a_q)
            ); // [RL1]
            if (g < 6) begin : g_gp
                assign gpr_main[g*8 +: 8] = m_q;
                assign bank_wr[g] = (reg_wr && (reg_sel == g)) ||
                                    gpr_upd;
                assign bank_wdata[g*8 +: 8] =
                    gpr_upd ? (g == 0 ? pair_d[15:8] :
                               (g == 1 ? pair_d[7:0] : m_q)) :
                    reg_wdata;
            end
        end
    endgenerate
    // Slot 6 swaps on EXAF but is never written; acc_q and flags_q hold A and F
    assign bank_wr[6] = 1'b0;
    assign bank_wdata[55:48] = 8'h00;
    assign acc_main = acc_q;
    assign flg_main = flags_q;

    // Alternate copies of accumulator and flags
    reg [7:0] acc_alt_q;
    reg [7:0] flg_alt_q;

    // Datapath next-state: ALU results, block ops and loads
    always @* begin
        acc_d = acc_q;
        flags_d = flags_q;
        acc_wr = 1'b0;
        flg_wr = 1'b0;
        gpr_upd = 1'b0;
        b_next = gpr_main[7:0] - 8'h01;
        bc_next = {gpr_main[7:0], gpr_main[15:8]} - 16'h0001;
        pair_d = {gpr_main[7:0], gpr_main[15:8]};
        case (op_cmd)
            `CRS_OP_ADD, `CRS_OP_ADC, `CRS_OP_SUB, `CRS_OP_SBC,
            `CRS_OP_AND, `CRS_OP_OR, `CRS_OP_XOR, `CRS_OP_DAA: begin
                acc_d = alu_res; // [RL2]
                acc_wr = 1'b1;
                flags_d = alu_flags; // [RL3]
                flg_wr = 1'b1;
            end
            `CRS_OP_CMP: begin
                flags_d = alu_flags;
                flg_wr = 1'b1;
            end
            `CRS_OP_LDA: begin
                acc_wr = 1'b1;
                if (acc_src == `CRS_SRC_BUS) begin
                    acc_d = operand; // [RL2]
                end else begin
                    acc_d = (acc_src == `CRS_SRC_IPAGE) ? ipage_q : refr_q;
                    flg_wr = 1'b1;
                    flags_d[`CRS_FLAG_NEG] = acc_d[7]; // [RL5]
                    flags_d[`CRS_FLAG_NULL] = (acc_d == 8'h00); // [RL6]
                    flags_d[`CRS_FLAG_NIB] = 1'b0;
                    flags_d[`CRS_FLAG_SUB] = 1'b0;
                    flags_d[`CRS_FLAG_PV] = interrupt_enable_latch; // [RL11]
                end
            end
            `CRS_OP_BSRCH: begin
                flg_wr = 1'b1;
                gpr_upd = 1'b1;
                pair_d = bc_next;
                flags_d[`CRS_FLAG_NEG] = alu_flags[`CRS_FLAG_NEG];
                flags_d[`CRS_FLAG_NIB] = alu_flags[`CRS_FLAG_NIB];
                flags_d[`CRS_FLAG_SUB] = 1'b1;
                flags_d[`CRS_FLAG_NULL] = (acc_q == operand); // [RL7]
                flags_d[`CRS_FLAG_PV] = (bc_next != 16'h0000); // [RL10]
            end
            `CRS_OP_BXFER: begin
                flg_wr = 1'b1;
                gpr_upd = 1'b1;
                pair_d = bc_next;
                flags_d[`CRS_FLAG_NIB] = 1'b0;
                flags_d[`CRS_FLAG_SUB] = 1'b0;
                flags_d[`CRS_FLAG_PV] = (bc_next != 16'h0000); // [RL10]
            end
            `CRS_OP_BIO: begin
                flg_wr = 1'b1;
                gpr_upd = 1'b1;
                pair_d = {b_next, gpr_main[15:8]};
                flags_d[`CRS_FLAG_SUB] = 1'b1;
                flags_d[`CRS_FLAG_NULL] = (b_next == 8'h00); // [RL8]
            end
            default: begin
                acc_d = acc_q;
                flags_d = swap_af ? flg_alt_q : flags_q; // [RL4]
            end
        endcase
    end

    // Accumulator, flag register and their alternate copies
    always @(posedge sys_clk) begin
        if (rst) begin
            acc_q <= `CRS_RST_BYTE;
            flags_q <= `CRS_RST_BYTE;
            acc_alt_q <= `CRS_RST_BYTE;
            flg_alt_q <= `CRS_RST_BYTE;
        end else if (swap_af) begin
            acc_q <= acc_alt_q; // [RL20]
            flags_q <= flg_alt_q; // [RL20]
            acc_alt_q <= acc_q;
            flg_alt_q <= flags_q;
        end else begin
            if (acc_wr)
                acc_q <= acc_d; // [RL2]
            if (flg_wr)
                flags_q <= flags_d; // [RL3] [RL21]
        end
    end

    // Testable conditions: sign, zero, parity/overflow, carry only
    always @(posedge sys_clk) begin
        if (rst)
            cond_q <= 4'h0;
        else
            cond_q <= {flags_d[`CRS_FLAG_NEG], flags_d[`CRS_FLAG_NULL],
                       flags_d[`CRS_FLAG_PV],
                       flags_d[`CRS_FLAG_CY]}; // [RL4] [RL15]
    end

    // Opcode latch on fetch strobe
    always @(posedge sys_clk) begin
        if (rst)
            opcode_q <= `CRS_RST_BYTE;
        else if (opcode_strobe)
            opcode_q <= data_in; // [RL17]
    end

    // Special registers: page, refresh, index, stack, program counter
    always @(posedge sys_clk) begin
        if (rst) begin
            ipage_q <= `CRS_RST_BYTE;
            refr_q <= `CRS_RST_BYTE;
            for (k = 0; k < 4; k = k + 1)
                word_q[k] <= `CRS_RST_WORD;
        end else begin
            if (ipage_wr)
                ipage_q <= reg_wdata;
            if (refresh_inc)
                refr_q <= {refr_q[7], refr_q[6:0] + 7'h01};
            if (word_wr)
                word_q[word_sel] <= word_wdata; // [RL1]
        end
    end

    // Visible copies of the register set
    always @(posedge sys_clk) begin
        if (rst) begin
            gpr_q <= 48'h000000000000;
            word_regs_q <= 64'h0000000000000000;
            ipage_refr_q <= `CRS_RST_WORD;
        end else begin
            gpr_q <= gpr_main;
            word_regs_q <= {word_q[3], word_q[2], word_q[1], word_q[0]};
            ipage_refr_q <= {ipage_q, refr_q};
        end
    end

    // Bus drivers; a claim releases both buses
    always @(posedge sys_clk) begin
        if (rst) begin
            addr_out_q <= `CRS_RST_WORD;
            addr_oe_n_q <= 1'b1;
            data_out_q <= `CRS_RST_BYTE;
            data_oe_n_q <= 1'b1;
            bus_released_q <= 1'b0;
        end else begin
            addr_out_q <= addr_drive;
            data_out_q <= data_drive;
            bus_released_q <= external_bus_claim; // [RL16]
            addr_oe_n_q <= external_bus_claim; // [RL16]
            data_oe_n_q <= external_bus_claim | ~data_dir_out; // [RL16]
        end
    end
endmodule
`default_nettype wire

// ===== hdl/crs_defines.vh
// Constants for the core register set and flag logic
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH
// Flag bit positions
`define CRS_FLAG_NEG 7
`define CRS_FLAG_NULL 6
`define CRS_FLAG_NIB 4
`define CRS_FLAG_PV 2
`define CRS_FLAG_SUB 1
`define CRS_FLAG_CY 0
// Reset values
`define CRS_RST_BYTE 8'h00
`define CRS_RST_WORD 16'h0000
// Operation codes of the datapath command
`define CRS_OP_NOP 4'h0
`define CRS_OP_ADD 4'h1
`define CRS_OP_ADC 4'h2
`define CRS_OP_SUB 4'h3
`define CRS_OP_SBC 4'h4
`define CRS_OP_AND 4'h5
`define CRS_OP_OR 4'h6
`define CRS_OP_XOR 4'h7
`define CRS_OP_CMP 4'h8
`define CRS_OP_DAA 4'h9
`define CRS_OP_LDA 4'hA
`define CRS_OP_EXAF 4'hB
`define CRS_OP_EXX 4'hC
`define CRS_OP_BSRCH 4'hD
`define CRS_OP_BXFER 4'hE
`define CRS_OP_BIO 4'hF
// Load sources for the accumulator
`define CRS_SRC_BUS 2'h0
`define CRS_SRC_IPAGE 2'h1
`define CRS_SRC_REFR 2'h2
// Main bank indices (b c d e h l)
`define CRS_R_B 3'h0
`define CRS_R_C 3'h1
`define CRS_R_D 3'h2
`define CRS_R_E 3'h3
`define CRS_R_H 3'h4
`define CRS_R_L 3'h5
`endif

// ===== hdl/crs_alu.v
// Combinational arithmetic unit with flag generation
`timescale 1ns/1ns
`default_nettype none
`include "crs_defines.vh"
module crs_alu (
    input wire [3:0] op,
    input wire [7:0] a_in,
    input wire [7:0] b_in,
    input wire [7:0] f_in,
    output reg [7:0] res,
    output reg [7:0] f_out
);
    reg [8:0] sum;
    reg [4:0] lo;
    reg cin;
    reg is_sub;
    reg is_arith;
    reg [7:0] corr;
    // Result and flags per operation class
    always @* begin
        sum = 9'h000;
        lo = 5'h00;
        corr = 8'h00;
        cin = 1'b0;
        is_sub = 1'b0;
        is_arith = 1'b0;
        res = a_in;
        f_out = f_in;
        case (op)
            `CRS_OP_ADD, `CRS_OP_ADC, `CRS_OP_SUB, `CRS_OP_SBC,
            `CRS_OP_CMP: begin
                is_arith = 1'b1;
                is_sub = (op == `CRS_OP_SUB) || (op == `CRS_OP_SBC) ||
                         (op == `CRS_OP_CMP);
                cin = ((op == `CRS_OP_ADC) || (op == `CRS_OP_SBC)) &
                      f_in[`CRS_FLAG_CY];
                if (is_sub) begin
                    sum = {1'b0, a_in} - {1'b0, b_in} - {8'h00, cin};
                    lo = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} -
                         {4'h0, cin};
                end else begin
                    sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin};
                    lo = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} +
                         {4'h0, cin};
                end
                if (op != `CRS_OP_CMP)
                    res = sum[7:0];
                f_out[`CRS_FLAG_CY] = sum[8]; // [RL14]
                f_out[`CRS_FLAG_NIB] = lo[4]; // [RL18]
                f_out[`CRS_FLAG_SUB] = is_sub; // [RL19]
                // Signed overflow out of +127..-128
                f_out[`CRS_FLAG_PV] = is_sub ? // [RL12] [RL13]
                    ((a_in[7] ^ b_in[7]) & (a_in[7] ^ sum[7])) :
                    (~(a_in[7] ^ b_in[7]) & (a_in[7] ^ sum[7]));
                f_out[`CRS_FLAG_NEG] = sum[7]; // [RL5]
                f_out[`CRS_FLAG_NULL] = (sum[7:0] == 8'h00); // [RL6]
            end
            `CRS_OP_AND, `CRS_OP_OR, `CRS_OP_XOR: begin
                if (op == `CRS_OP_AND)
                    res = a_in & b_in;
                else if (op == `CRS_OP_OR)
                    res = a_in | b_in;
                else
                    res = a_in ^ b_in;
                f_out[`CRS_FLAG_CY] = 1'b0;
                f_out[`CRS_FLAG_NIB] = (op == `CRS_OP_AND);
                f_out[`CRS_FLAG_SUB] = 1'b0;
                f_out[`CRS_FLAG_PV] = ~(^res); // [RL9] [RL13]
                f_out[`CRS_FLAG_NEG] = res[7]; // [RL5]
                f_out[`CRS_FLAG_NULL] = (res == 8'h00); // [RL6]
            end
            `CRS_OP_DAA: begin
                // Decimal correction chosen by half carry, carry and the accumulator digits; subtract flag sets its sign
                if (f_in[`CRS_FLAG_NIB] || (a_in[3:0] > 4'h9))
                    corr[3:0] = 4'h6; // [RL18]
                if (f_in[`CRS_FLAG_CY] || (a_in > 8'h99)) begin
                    corr[7:4] = 4'h6;
                    f_out[`CRS_FLAG_CY] = 1'b1;
                end
                if (f_in[`CRS_FLAG_SUB]) begin // [RL19]
                    res = a_in - corr;
                    f_out[`CRS_FLAG_NIB] = f_in[`CRS_FLAG_NIB] &
                                           (a_in[3:0] < 4'h6);
                end else begin
                    res = a_in + corr;
                    f_out[`CRS_FLAG_NIB] = (a_in[3:0] > 4'h9);
                end
                f_out[`CRS_FLAG_PV] = ~(^res);
                f_out[`CRS_FLAG_NEG] = res[7]; // [RL5]
                f_out[`CRS_FLAG_NULL] = (res == 8'h00); // [RL6]
            end
            default: begin
                res = a_in;
                f_out = f_in;
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== hdl/crs_bank.v
// One eight-bit register with swap partner for the alternate bank
`timescale 1ns/1ns
`default_nettype none
`include "crs_defines.vh"
module crs_bank #(
    parameter WIDTH = 8
) (
    input wire sys_clk,
    input wire rst,
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    input wire swap,
    output reg [WIDTH-1:0] main_q,
    output reg [WIDTH-1:0] alt_q
);
    // Swap has priority; the alternate copy is only reached by swap
    always @(posedge sys_clk) begin
        if (rst) begin
            main_q <= {WIDTH{1'b0}};
            alt_q <= {WIDTH{1'b0}};
        end else if (swap) begin
            main_q <= alt_q; // [RL20]
            alt_q <= main_q; // [RL20]
        end else if (wr_en) begin
            main_q <= wr_data;
        end
    end
endmodule
`default_nettype wire

// ===== verification/crs_bus_mem.sv
// Behavioural memory on the far side of the processor bus
`timescale 1ns/1ns
`default_nettype none
module crs_bus_mem (
    input wire logic sys_clk,
    input wire logic [15:0] addr_out_q,
    input wire logic addr_oe_n_q,
    input wire logic [7:0] data_out_q,
    input wire logic data_oe_n_q,
    output logic [7:0] data_in
);
    logic [7:0] mem [0:15];
    logic [7:0] last_q;

    // Known start contents
    initial begin
        for (int i = 0; i < 16; i++)
            mem[i] = 8'h00;
        last_q = 8'h00;
    end

    // Store while the core drives, answer only while it listens
    always @(posedge sys_clk) begin
        if (!addr_oe_n_q && !data_oe_n_q)
            mem[addr_out_q[3:0]] <= data_out_q;
        if (!addr_oe_n_q && data_oe_n_q)
            last_q <= mem[addr_out_q[3:0]];
        else
            last_q <= ~last_q; // Released lines hold no stale value
    end

    assign data_in = last_q;
endmodule
`default_nettype wire

// ===== verification/crs_core_properties.sv
// Port-level assertions for the register set and flag logic
`timescale 1ns/1ns
`default_nettype none
`include "crs_defines.vh"
module crs_core_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic opcode_strobe,
    input wire logic [7:0] data_in,
    input wire logic [3:0] op_cmd,
    input wire logic [7:0] operand,
    input wire logic [1:0] acc_src,
    input wire logic interrupt_enable_latch,
    input wire logic external_bus_claim,
    input wire logic [7:0] data_drive,
    input wire logic data_dir_out,
    input wire logic [7:0] opcode_q,
    input wire logic [7:0] acc_q,
    input wire logic [7:0] flags_q,
    input wire logic [3:0] cond_q,
    input wire logic addr_oe_n_q,
    input wire logic [7:0] data_out_q,
    input wire logic data_oe_n_q,
    input wire logic bus_released_q
);
    wire logic [8:0] sum9;
    wire logic arith;
    wire logic logic_op;

    // Operation classes and add carry
    assign sum9 = {1'b0, acc_q} + {1'b0, operand};
    assign arith = op_cmd >= `CRS_OP_ADD && op_cmd <= `CRS_OP_XOR;
    assign logic_op = op_cmd >= `CRS_OP_AND && op_cmd <= `CRS_OP_XOR;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Bus states one cycle after the request
    sequence s_released;
        addr_oe_n_q && data_oe_n_q && bus_released_q;
    endsequence
    sequence s_driving;
        !data_oe_n_q && data_out_q == $past(data_drive);
    endsequence

    a_bus_release:
        assert property (external_bus_claim |=> s_released)
        else $error("bus kept after claim");
    a_bus_drive:
        assert property (!external_bus_claim && data_dir_out |=> s_driving)
        else $error("data bus not driven");
    a_opcode_latch:
        assert property (opcode_strobe |=> opcode_q == $past(data_in))
        else $error("opcode not latched");
    a_cond_mirror:
        assert property (cond_q == {flags_q[7:6], flags_q[2], flags_q[0]})
        else $error("condition bits differ from flags");
    a_spare_bits:
        assert property (flags_q[5] == 1'b0 && flags_q[3] == 1'b0)
        else $error("unused flag bit set");
    a_sign_acc:
        assert property (arith |=> flags_q[7] == acc_q[7])
        else $error("sign flag wrong");
    a_zero_result:
        assert property (arith |=> flags_q[6] == (acc_q == 8'h00))
        else $error("zero flag wrong");
    a_logic_parity:
        assert property (logic_op |=> flags_q[2] == ~^acc_q)
        else $error("parity flag wrong");
    a_lda_latch:
        assert property (op_cmd == `CRS_OP_LDA && acc_src != `CRS_SRC_BUS
            |=> flags_q[2] == $past(interrupt_enable_latch))
        else $error("interrupt latch not copied");
    a_add_carry:
        assert property (op_cmd == `CRS_OP_ADD |=> flags_q[0] == $past(sum9[8]))
        else $error("add carry wrong");
    a_srch_zero:
        assert property (op_cmd == `CRS_OP_BSRCH
            |=> flags_q[6] == ($past(acc_q) == $past(operand)))
        else $error("search match flag wrong");
endmodule

bind crs_core crs_core_properties i_props (
    .sys_clk(sys_clk), .rst(rst), .opcode_strobe(opcode_strobe),
    .data_in(data_in), .op_cmd(op_cmd), .operand(operand),
    .acc_src(acc_src), .interrupt_enable_latch(interrupt_enable_latch),
    .external_bus_claim(external_bus_claim), .data_drive(data_drive),
    .data_dir_out(data_dir_out), .opcode_q(opcode_q), .acc_q(acc_q),
    .flags_q(flags_q), .cond_q(cond_q), .addr_oe_n_q(addr_oe_n_q),
    .data_out_q(data_out_q), .data_oe_n_q(data_oe_n_q),
    .bus_released_q(bus_released_q)
);
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the register set and flag logic
`timescale 1ns/1ns
`default_nettype none
`include "crs_defines.vh"
module tb;
    logic sys_clk = 1'b0;
    logic rst, opcode_strobe, reg_wr, word_wr, ipage_wr, refresh_inc;
    logic interrupt_enable_latch, external_bus_claim, data_dir_out;
    logic [3:0] op_cmd, op, cond_q;
    logic [7:0] operand, reg_wdata, data_drive, b, acc_m, flags_m;
    logic [7:0] opcode_q, acc_q, flags_q, data_out_q;
    logic [1:0] acc_src, word_sel;
    logic [2:0] reg_sel;
    logic [15:0] word_wdata, addr_drive, addr_out_q, ipage_refr_q, r;
    wire logic [7:0] data_in;
    logic addr_oe_n_q, data_oe_n_q, bus_released_q;
    logic [47:0] gpr_q;
    logic [63:0] word_regs_q;
    int bad_count = 0;
    int cmp_count = 0;
    logic [3:0] c_op [0:6] = '{`CRS_OP_ADD, `CRS_OP_ADD, `CRS_OP_SUB,
        `CRS_OP_SUB, `CRS_OP_ADC, `CRS_OP_AND, `CRS_OP_XOR};
    logic [7:0] c_b [0:6] = '{8'h7F, 8'h01, 8'h01, 8'h80, 8'h01, 8'h00, 8'hFF};

    always #4 sys_clk = ~sys_clk;

    crs_core i_dut (
        .sys_clk(sys_clk), .rst(rst), .opcode_strobe(opcode_strobe),
        .data_in(data_in), .op_cmd(op_cmd), .operand(operand),
        .acc_src(acc_src), .reg_wr(reg_wr), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .word_wr(word_wr), .word_sel(word_sel),
        .word_wdata(word_wdata), .ipage_wr(ipage_wr),
        .refresh_inc(refresh_inc),
        .interrupt_enable_latch(interrupt_enable_latch),
        .external_bus_claim(external_bus_claim), .addr_drive(addr_drive),
        .data_drive(data_drive), .data_dir_out(data_dir_out),
        .opcode_q(opcode_q), .acc_q(acc_q), .flags_q(flags_q),
        .cond_q(cond_q), .addr_out_q(addr_out_q), .addr_oe_n_q(addr_oe_n_q),
        .data_out_q(data_out_q), .data_oe_n_q(data_oe_n_q),
        .bus_released_q(bus_released_q), .gpr_q(gpr_q),
        .word_regs_q(word_regs_q), .ipage_refr_q(ipage_refr_q)
    );

    crs_bus_mem i_mem (
        .sys_clk(sys_clk), .addr_out_q(addr_out_q), .addr_oe_n_q(addr_oe_n_q),
        .data_out_q(data_out_q), .data_oe_n_q(data_oe_n_q), .data_in(data_in)
    );

    // Expected {result, flags} of a command
    function automatic [15:0] alu(input [3:0] o, input [7:0] a, input [7:0] d,
        input c);
        reg [8:0] s;
        reg [4:0] h;
        reg cc, sb, v;
        begin
            cc = (o == `CRS_OP_ADC || o == `CRS_OP_SBC) ? c : 1'b0;
            sb = (o == `CRS_OP_SUB || o == `CRS_OP_SBC);
            s = sb ? a - d - cc : a + d + cc;
            h = sb ? a[3:0] - d[3:0] - cc : a[3:0] + d[3:0] + cc;
            v = (sb ? a[7] != d[7] : a[7] == d[7]) && s[7] != a[7];
            alu = {s[7:0], s[7], s[7:0] == 8'h00, 1'b0, h[4], 1'b0, v, sb, s[8]};
            if (o >= `CRS_OP_AND) begin
                s[7:0] = o == `CRS_OP_AND ? a & d : o == `CRS_OP_OR ? a | d : a ^ d;
                alu = {s[7:0], s[7], s[7:0] == 8'h00, 1'b0, o == `CRS_OP_AND,
                    1'b0, ~^s[7:0], 2'b00};
            end
        end
    endfunction

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // One datapath command held for a single cycle
    task automatic run(input logic [3:0] o, input logic [7:0] d,
        input logic [1:0] src);
        op_cmd = o;
        operand = d;
        acc_src = src;
        tick(1);
        op_cmd = `CRS_OP_NOP;
        tick(1);
    endtask

    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        {opcode_strobe, reg_wr, word_wr, ipage_wr, refresh_inc} = 5'h00;
        {interrupt_enable_latch, external_bus_claim, data_dir_out} = 3'h0;
        {op_cmd, operand, acc_src, reg_sel, reg_wdata} = 25'h0;
        {word_sel, word_wdata, addr_drive, data_drive} = 42'h0;
        rst = 1'b1;
        r = 16'($urandom(32'h3C08));
        tick(6);
        rst = 1'b0;
        acc_m = 8'h00;
        flags_m = 8'h00;
        for (int i = 0; i < 67; i++) begin
            op = i < 7 ? c_op[i] : 4'(1 + $urandom % 7);
            b = i < 7 ? c_b[i] : 8'($urandom);
            r = alu(op, acc_m, b, flags_m[0]);
            run(op, b, `CRS_SRC_BUS);
            acc_m = r[15:8];
            flags_m = r[7:0];
            chk(acc_q, acc_m);
            chk(flags_q[7:6], flags_m[7:6]);
            chk(flags_q[2], flags_m[2]);
            chk(flags_q[0], flags_m[0]);
            chk(flags_q[4:1], flags_m[4:1]);
            chk(flags_q, flags_m);
            chk(cond_q, {flags_m[7:6], flags_m[2], flags_m[0]});
        end
        run(`CRS_OP_CMP, acc_m, `CRS_SRC_BUS);
        chk({acc_q, flags_q[6]}, {acc_m, 1'b1});
        run(`CRS_OP_CMP, acc_m + 8'h01, `CRS_SRC_BUS);
        chk(flags_q[6], 1'b0);
        $display("test arithmetic done");
        wr(`CRS_R_B, 8'h00);
        wr(`CRS_R_C, 8'h01);
        run(`CRS_OP_BSRCH, acc_m, `CRS_SRC_BUS);
        chk({flags_q[6], flags_q[2]}, 2'b10);
        run(`CRS_OP_BSRCH, ~acc_m, `CRS_SRC_BUS);
        chk({flags_q[6], flags_q[2]}, 2'b01);
        run(`CRS_OP_BXFER, 8'h00, `CRS_SRC_BUS);
        chk(flags_q[2], 1'b1);
        tick(1);
        chk(gpr_q[15:0], 16'hFEFF);
        wr(`CRS_R_B, 8'h01);
        run(`CRS_OP_BIO, 8'h00, `CRS_SRC_BUS);
        chk(flags_q[6], 1'b1);
        run(`CRS_OP_BIO, 8'h00, `CRS_SRC_BUS);
        chk(flags_q[6], 1'b0);
        $display("test block done");
        ipage_wr = 1'b1;
        reg_wdata = 8'hA5;
        tick(1);
        ipage_wr = 1'b0;
        refresh_inc = 1'b1;
        tick(3);
        refresh_inc = 1'b0;
        interrupt_enable_latch = 1'b1;
        run(`CRS_OP_LDA, 8'h00, `CRS_SRC_IPAGE);
        chk({acc_q, flags_q[2]}, {8'hA5, 1'b1});
        interrupt_enable_latch = 1'b0;
        run(`CRS_OP_LDA, 8'h00, `CRS_SRC_REFR);
        chk({acc_q, flags_q[2]}, {8'h03, 1'b0});
        chk(ipage_refr_q, 16'hA503);
        run(`CRS_OP_ADD, 8'h0F, `CRS_SRC_BUS);
        run(`CRS_OP_DAA, 8'h00, `CRS_SRC_BUS);
        chk(acc_q, 8'h18);
        run(`CRS_OP_LDA, 8'h55, `CRS_SRC_BUS);
        run(`CRS_OP_EXAF, 8'h00, `CRS_SRC_BUS);
        chk({acc_q, flags_q}, 16'h0000);
        run(`CRS_OP_EXAF, 8'h00, `CRS_SRC_BUS);
        chk(acc_q, 8'h55);
        wr(`CRS_R_B, 8'h12);
        run(`CRS_OP_EXX, 8'h00, `CRS_SRC_BUS);
        tick(1);
        chk(gpr_q[7:0], 8'h00);
        run(`CRS_OP_EXX, 8'h00, `CRS_SRC_BUS);
        tick(1);
        chk(gpr_q[7:0], 8'h12);
        r = 16'($urandom);
        word_sel = 2'h2;
        word_wdata = r;
        word_wr = 1'b1;
        tick(1);
        word_wr = 1'b0;
        tick(1);
        chk(word_regs_q[47:32], r);
        $display("test registers done");
        addr_drive = 16'h0003;
        data_drive = 8'hC3;
        data_dir_out = 1'b1;
        tick(2);
        chk({addr_oe_n_q, data_oe_n_q, addr_out_q[7:0]}, 10'h003);
        data_dir_out = 1'b0;
        tick(2);
        opcode_strobe = 1'b1;
        tick(1);
        opcode_strobe = 1'b0;
        chk(opcode_q, 8'hC3);
        external_bus_claim = 1'b1;
        tick(1);
        chk({addr_oe_n_q, data_oe_n_q, bus_released_q}, 3'b111);
        external_bus_claim = 1'b0;
        tick(1);
        chk(bus_released_q, 1'b0);
        $display("test bus done");
        results;
    end

    // Guard against a hang
    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        results;
    end
endmodule
`default_nettype wire
